//--- core/pesc_consts.vh
// Purpose: constants for the per-port extended status and control bank
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   offsets, field positions, reset values and strap-free defaults
//
// Contract
// - live descrambler lock and gigabit link flags
// - gigabit error events latch until read
// - transmit disable bit turns transmitter off
// - sticky bit disables crossover at forced speed
// - sticky bits disable pair swap, polarity correction
// - parallel detect bit honours advertised ability
// - bit stops automatic gigabit next page exchange
// - clock output enable, default from strap
// - sticky bit forces ten-base link pass
// - sticky bits disable jabber and echo
// - two-bit squelch threshold select
// - sticky reset enable governs soft reset
// - super-sticky bits survive every soft reset
// - ten-base event flags and live link
// - broadcast write enable, reads stay local
// - MAC autoneg enable and MAC protocol select
// - media mode field selects fixed medium
// - upper media codes enable automatic selection
// - override field forces or frees selection
// - alignment error flag, eeprom present status
// - mode bits apply at next soft reset
`ifndef PESC_CONSTS_VH
`define PESC_CONSTS_VH

// register offsets
`define PESC_ADDR_GIG_STAT   5'h11
`define PESC_ADDR_BYPASS     5'h12
`define PESC_ADDR_TEN_EXT    5'h16
`define PESC_ADDR_MEDIA_MAC  5'h17

// gigabit copper status field positions
`define PESC_GIG_LOCK_BIT    15
`define PESC_GIG_LINK_BIT    12

// bypass control field positions
`define PESC_BYP_TXDIS_BIT   15
`define PESC_BYP_TCLK_BIT    8
`define PESC_BYP_MDIX_BIT    7
`define PESC_BYP_PSWAP_BIT   5
`define PESC_BYP_POL_BIT     4
`define PESC_BYP_PDET_BIT    3
`define PESC_BYP_NPAGE_BIT   1
`define PESC_BYP_CLKO_BIT    0

// ten-base extended control field positions
`define PESC_TEN_FLINK_BIT   15
`define PESC_TEN_JAB_BIT     14
`define PESC_TEN_ECHO_BIT    13
`define PESC_TEN_SQ_HI       11
`define PESC_TEN_SQ_LO       10
`define PESC_TEN_STKEN_BIT   9
`define PESC_TEN_LINK_BIT    6
`define PESC_TEN_BCAST_BIT   0

// media and MAC mode field positions
`define PESC_MM_ANEG_BIT     13
`define PESC_MM_PROTO_BIT    12
`define PESC_MM_PREF_BIT     11
`define PESC_MM_MODE_HI      10
`define PESC_MM_MODE_LO      8
`define PESC_MM_OVR_HI       7
`define PESC_MM_OVR_LO       6
`define PESC_MM_FELB_BIT     3

// reset values of the writable bits
`define PESC_RST_TXDIS       1'h0
`define PESC_RST_TCLK        1'h0
`define PESC_RST_MDIX        1'h1
`define PESC_RST_PSWAP       1'h0
`define PESC_RST_POL         1'h0
`define PESC_RST_PDET        1'h1
`define PESC_RST_NPAGE       1'h0
`define PESC_RST_FLINK       1'h0
`define PESC_RST_JAB         1'h0
`define PESC_RST_ECHO        1'h1
`define PESC_RST_SQ          2'h0
`define PESC_RST_STKEN       1'h1
`define PESC_RST_BCAST       1'h0
`define PESC_RST_PROTO       1'h0
`define PESC_RST_PREF        1'h0
`define PESC_RST_OVR         2'h0
`define PESC_RST_FELB        1'h0

// event flag vector layout: gigabit 9:3, ten-base 2:1, alignment 0
`define PESC_EVT_W           10

`endif

//--- core/pesc_rc_flags.v
// Purpose: bank of latched event flags that clear when read
// Assumes: events and clear strobes come from the same clock domain
// Notes:   an event in the clearing cycle keeps its flag set
`timescale 1ns/10ps
module pesc_rc_flags #(
  parameter W = 10
) (
  // clock and reset
  input  wire         clk,
  input  wire         rstn,
  // event pulses and per-bit clear strobes
  input  wire [W-1:0] evt,
  input  wire [W-1:0] clr,
  // latched flags
  output wire [W-1:0] flags
);

  genvar i;

  ////////////////////////////////////////////////////////////////////////
  // one flip-flop per flag, set wins over clear
  generate
    for (i = 0; i < W; i = i + 1) begin : gFlag
      reg flag_r;  // latched event
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_r <= 1'b0;
        end else begin
          flag_r <= evt[i] | (flag_r & ~clr[i]);
        end
      end
      assign flags[i] = flag_r;
    end
  endgenerate

endmodule // pesc_rc_flags

//--- core/pesc_regs.v
// Purpose: per-port extended status and control register bank
// Assumes: everything but straps and eeprom sense runs on clk
// Notes:   media/MAC aneg, protocol, preference and mode fields are staged and take hold at soft reset
`timescale 1ns/10ps
`include "pesc_consts.vh"
module pesc_regs (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // management access for this port
  input  wire [4:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWrEn,
  input  wire        regRdEn,
  output reg  [15:0] regRdData,
  // write broadcast by another port of the device
  input  wire [4:0]  extWrAddr,
  input  wire [15:0] extWrData,
  input  wire        extWrEn,
  // software reset pulse from the basic control register
  input  wire        swReset,
  // configuration straps and eeprom sense (pins)
  input  wire        strapClkOut,
  input  wire        strapMacAneg,
  input  wire [2:0]  strapMedia,
  input  wire        eepromSense,
  // live status and event pulses from the PHY core
  input  wire        gigDescrLock,
  input  wire        gigLinkUp,
  input  wire        tenLinkUp,
  input  wire [6:0]  gigEvents,
  input  wire        tenEofErr,
  input  wire        tenDisconnect,
  input  wire        sgmiiAlignErr,
  input  wire        forcedSpeedLow,
  // controls toward the PHY core
  output reg         txDisable,
  output reg         testClkEn,
  output reg         autoMdixOff,
  output reg         pairSwapOff,
  output reg         polarityCorrOff,
  output reg         parallelDetHonour,
  output reg         nextPageAutoOff,
  output reg         clkOutEn,
  output reg         forceLinkPass,
  output reg         jabberOff,
  output reg         echoOff,
  output reg  [1:0]  squelchSel,
  output reg         bcastWrEn,
  output reg         macAnegEn,
  output reg         macProto1000x,
  output reg         preferCopper,
  output reg  [2:0]  mediaMode,
  output reg         autoMediaSel,
  output reg  [1:0]  mediaOverride,
  output reg         farEndLoop
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [1:0]  rstSync_r;      // reset release synchroniser
  wire        rstnInt;        // synchronised reset
  reg  [4:0]  strapMeta_r;    // first stage of pin sync
  reg  [4:0]  strapSync_r;    // second stage of pin sync
  reg         eeMeta_r;       // eeprom sense first stage
  reg         eeSync_r;       // eeprom sense second stage
  reg         strapLoad_r;    // high for the one cycle that captures the straps
  // staged media/MAC fields, written by software
  reg         stgAneg_r;
  reg         stgProto_r;
  reg         stgPref_r;
  reg  [2:0]  stgMode_r;
  // strap-derived default held for soft reset
  reg         dfltClkOut_r;
  reg         mdixBit_r;      // crossover-off bit
  reg         stkKeep_r;      // sticky reset enable
  // effective write port (own or broadcast)
  wire        wrEn;
  wire [4:0]  wrAddr;
  wire [15:0] wrData;
  wire        stickyRst;      // soft reset that restores sticky bits
  // event flags
  wire [`PESC_EVT_W-1:0] evtVec;
  wire [`PESC_EVT_W-1:0] clrVec;
  wire [`PESC_EVT_W-1:0] flags;
  reg  [15:0] rdMux;          // combinational read value

  ////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstnInt = rstSync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers for straps and eeprom sense
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      strapMeta_r <= 5'h00;
      strapSync_r <= 5'h00;
      eeMeta_r    <= 1'b0;
      eeSync_r    <= 1'b0;
    end else begin
      strapMeta_r <= {strapClkOut, strapMacAneg, strapMedia};
      strapSync_r <= strapMeta_r;
      eeMeta_r    <= eepromSense;
      eeSync_r    <= eeMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture: waits for the sync chain to fill, then loads once
  reg [1:0] strapWait_r;  // cycles since reset release
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      strapWait_r <= 2'h0;
      strapLoad_r <= 1'b0;
    end else begin
      if (strapWait_r != 2'h3) begin
        strapWait_r <= strapWait_r + 2'h1;
      end
      strapLoad_r <= (strapWait_r == 2'h2);  // one-cycle load pulse
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write port: own write has priority over a broadcast one
  assign wrEn   = regWrEn | extWrEn;
  assign wrAddr = regWrEn ? regAddr   : extWrAddr;
  assign wrData = regWrEn ? regWrData : extWrData;

  // sticky bits go back to defaults only when sticky reset is off
  assign stickyRst = swReset & ~stkKeep_r;

  ////////////////////////////////////////////////////////////////////////
  // bypass control register
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      txDisable         <= `PESC_RST_TXDIS;
      testClkEn         <= `PESC_RST_TCLK;
      mdixBit_r         <= `PESC_RST_MDIX;
      pairSwapOff       <= `PESC_RST_PSWAP;
      polarityCorrOff   <= `PESC_RST_POL;
      parallelDetHonour <= `PESC_RST_PDET;
      nextPageAutoOff   <= `PESC_RST_NPAGE;
      clkOutEn          <= 1'b0;
    end else begin
      if (strapLoad_r) begin
        clkOutEn <= strapSync_r[4];
      end
      if (swReset) begin
        // plain bits always return to defaults
        txDisable <= `PESC_RST_TXDIS;
        testClkEn <= `PESC_RST_TCLK;
      end
      if (stickyRst) begin
        mdixBit_r         <= `PESC_RST_MDIX;
        pairSwapOff       <= `PESC_RST_PSWAP;
        polarityCorrOff   <= `PESC_RST_POL;
        parallelDetHonour <= `PESC_RST_PDET;
        nextPageAutoOff   <= `PESC_RST_NPAGE;
        clkOutEn          <= dfltClkOut_r;
      end
      if (wrEn && wrAddr == `PESC_ADDR_BYPASS) begin
        txDisable         <= wrData[`PESC_BYP_TXDIS_BIT];
        testClkEn         <= wrData[`PESC_BYP_TCLK_BIT];
        mdixBit_r         <= wrData[`PESC_BYP_MDIX_BIT];
        pairSwapOff       <= wrData[`PESC_BYP_PSWAP_BIT];
        polarityCorrOff   <= wrData[`PESC_BYP_POL_BIT];
        parallelDetHonour <= wrData[`PESC_BYP_PDET_BIT];
        nextPageAutoOff   <= wrData[`PESC_BYP_NPAGE_BIT];
        clkOutEn          <= wrData[`PESC_BYP_CLKO_BIT];
      end
    end
  end

  // crossover is turned off only at forced 10/100 with the bit set
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      autoMdixOff <= 1'b0;
    end else begin
      autoMdixOff <= mdixBit_r & forcedSpeedLow;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ten-base extended control register
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      forceLinkPass <= `PESC_RST_FLINK;
      jabberOff     <= `PESC_RST_JAB;
      echoOff       <= `PESC_RST_ECHO;
      squelchSel    <= `PESC_RST_SQ;
      bcastWrEn     <= `PESC_RST_BCAST;
      stkKeep_r     <= `PESC_RST_STKEN;
    end else begin
      if (stickyRst) begin
        forceLinkPass <= `PESC_RST_FLINK;
        jabberOff     <= `PESC_RST_JAB;
        echoOff       <= `PESC_RST_ECHO;
        squelchSel    <= `PESC_RST_SQ;
        bcastWrEn     <= `PESC_RST_BCAST;
      end
      // sticky reset enable is super-sticky: no soft reset term
      if (wrEn && wrAddr == `PESC_ADDR_TEN_EXT) begin
        forceLinkPass <= wrData[`PESC_TEN_FLINK_BIT];
        jabberOff     <= wrData[`PESC_TEN_JAB_BIT];
        echoOff       <= wrData[`PESC_TEN_ECHO_BIT];
        squelchSel    <=
          wrData[`PESC_TEN_SQ_HI:`PESC_TEN_SQ_LO];
        stkKeep_r     <= wrData[`PESC_TEN_STKEN_BIT];
        bcastWrEn     <= wrData[`PESC_TEN_BCAST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // media and MAC mode register: staged fields and live outputs
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      stgAneg_r     <= 1'b0;
      stgProto_r    <= `PESC_RST_PROTO;
      stgPref_r     <= `PESC_RST_PREF;
      stgMode_r     <= 3'h0;
      dfltClkOut_r  <= 1'b0;
      macAnegEn     <= 1'b0;
      macProto1000x <= `PESC_RST_PROTO;
      preferCopper  <= `PESC_RST_PREF;
      mediaMode     <= 3'h0;
      mediaOverride <= `PESC_RST_OVR;
      farEndLoop    <= `PESC_RST_FELB;
    end else begin
      if (strapLoad_r) begin
        // straps set both the staged and the active copies
        dfltClkOut_r <= strapSync_r[4];
        stgAneg_r    <= strapSync_r[3];
        stgMode_r    <= strapSync_r[2:0];
        macAnegEn    <= strapSync_r[3];
        mediaMode    <= strapSync_r[2:0];
      end
      if (swReset) begin
        // staged super-sticky fields take hold, never reset
        macAnegEn     <= stgAneg_r;
        macProto1000x <= stgProto_r;
        preferCopper  <= stgPref_r;
        mediaMode     <= stgMode_r;
        mediaOverride <= `PESC_RST_OVR;
        farEndLoop    <= `PESC_RST_FELB;
      end
      if (wrEn && wrAddr == `PESC_ADDR_MEDIA_MAC) begin
        stgAneg_r     <= wrData[`PESC_MM_ANEG_BIT];
        stgProto_r    <= wrData[`PESC_MM_PROTO_BIT];
        stgPref_r     <= wrData[`PESC_MM_PREF_BIT];
        stgMode_r     <= wrData[`PESC_MM_MODE_HI:`PESC_MM_MODE_LO];
        mediaOverride <= wrData[`PESC_MM_OVR_HI:`PESC_MM_OVR_LO];
        farEndLoop    <= wrData[`PESC_MM_FELB_BIT];
      end
    end
  end

  // automatic selection runs for codes 101, 110 and 111 only
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      autoMediaSel <= 1'b0;
    end else begin
      autoMediaSel <= mediaMode[2] & (mediaMode[1:0] != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags, cleared by the read that returns them
  assign evtVec = {gigEvents, tenEofErr, tenDisconnect, sgmiiAlignErr};
  assign clrVec = {{7{regRdEn && regAddr == `PESC_ADDR_GIG_STAT}},
                   {2{regRdEn && regAddr == `PESC_ADDR_TEN_EXT}},
                   regRdEn && regAddr == `PESC_ADDR_MEDIA_MAC};

  pesc_rc_flags #(
    .W     (`PESC_EVT_W)
  ) uFlags (
    .clk   (clk),
    .rstn  (rstnInt),
    .evt   (evtVec),
    .clr   (clrVec),
    .flags (flags)
  );

  ////////////////////////////////////////////////////////////////////////
  // read multiplexer; reserved bits and unmapped addresses read zero
  always @* begin
    rdMux = 16'h0000;
    case (regAddr)
      `PESC_ADDR_GIG_STAT: begin
        rdMux[`PESC_GIG_LOCK_BIT] = gigDescrLock;
        rdMux[`PESC_GIG_LINK_BIT] = gigLinkUp;
        rdMux[14:13] = flags[9:8];
        rdMux[11:7]  = flags[7:3];
      end
      `PESC_ADDR_BYPASS: begin
        rdMux[`PESC_BYP_TXDIS_BIT] = txDisable;
        rdMux[`PESC_BYP_TCLK_BIT]  = testClkEn;
        rdMux[`PESC_BYP_MDIX_BIT]  = mdixBit_r;
        rdMux[`PESC_BYP_PSWAP_BIT] = pairSwapOff;
        rdMux[`PESC_BYP_POL_BIT]   = polarityCorrOff;
        rdMux[`PESC_BYP_PDET_BIT]  = parallelDetHonour;
        rdMux[`PESC_BYP_NPAGE_BIT] = nextPageAutoOff;
        rdMux[`PESC_BYP_CLKO_BIT]  = clkOutEn;
      end
      `PESC_ADDR_TEN_EXT: begin
        rdMux[`PESC_TEN_FLINK_BIT] = forceLinkPass;
        rdMux[`PESC_TEN_JAB_BIT]   = jabberOff;
        rdMux[`PESC_TEN_ECHO_BIT]  = echoOff;
        rdMux[`PESC_TEN_SQ_HI:`PESC_TEN_SQ_LO] = squelchSel;
        rdMux[`PESC_TEN_STKEN_BIT] = stkKeep_r;
        rdMux[8:7]                 = flags[2:1];
        rdMux[`PESC_TEN_LINK_BIT]  = tenLinkUp;
        rdMux[`PESC_TEN_BCAST_BIT] = bcastWrEn;
      end
      `PESC_ADDR_MEDIA_MAC: begin
        rdMux[`PESC_MM_ANEG_BIT]  = stgAneg_r;
        rdMux[`PESC_MM_PROTO_BIT] = stgProto_r;
        rdMux[`PESC_MM_PREF_BIT]  = stgPref_r;
        rdMux[`PESC_MM_MODE_HI:`PESC_MM_MODE_LO] = stgMode_r;
        rdMux[`PESC_MM_OVR_HI:`PESC_MM_OVR_LO]   = mediaOverride;
        rdMux[`PESC_MM_FELB_BIT]  = farEndLoop;
        rdMux[1] = flags[0];
        rdMux[0] = eeSync_r;
      end
      default: begin
        rdMux = 16'h0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // read data register, loaded on the read strobe and then held
  always @(posedge clk or negedge rstnInt) begin
    if (!rstnInt) begin
      regRdData <= 16'h0000;
    end else if (regRdEn) begin
      regRdData <= rdMux;  // reads stay local even in broadcast
    end
  end

endmodule // pesc_regs

//--- verif/pesc_smi_host.sv
// Purpose: management host model driving one port's register access
// Assumes: every task is entered 1 ns after a rising clk edge
// Notes:   released lines show the inverse of their last value
`timescale 1ns/10ps
module pesc_smi_host (
  // clock
  input  wire         clk,
  // own port access
  output logic [4:0]  regAddr,
  output logic [15:0] regWrData,
  output logic        regWrEn,
  output logic        regRdEn,
  input  wire  [15:0] regRdData,
  // write arriving from a sibling port
  output logic [4:0]  extWrAddr,
  output logic [15:0] extWrData,
  output logic        extWrEn,
  // soft reset pulse
  output logic        swReset
);
  // idle bus at time zero
  initial begin
    {regAddr, regWrData, regWrEn, regRdEn, extWrAddr, extWrData, extWrEn,
      swReset} = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // own write; a spare edge keeps strobes from toggling twice at once
  task wr(input logic [4:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk) #1;
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    @(posedge clk) #1;
  endtask
  // write fanned out from another port
  task ext_wr(input logic [4:0] a, input logic [15:0] d);
    extWrAddr = a;
    extWrData = d;
    extWrEn = 1'b1;
    @(posedge clk) #1;
    extWrEn = 1'b0;
    extWrAddr = ~a;
    extWrData = ~d;
    @(posedge clk) #1;
  endtask
  // read strobe held n edges, data taken once it stands
  task rd(input logic [4:0] a, input int n, output logic [15:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    repeat (n) @(posedge clk) #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    @(posedge clk) #1;
    d = regRdData;
  endtask
  // soft reset commits staged mode edits before use
  task sr();
    swReset = 1'b1;
    @(posedge clk) #1;
    swReset = 1'b0;
    repeat (2) @(posedge clk) #1;
  endtask
endmodule // pesc_smi_host

//--- verif/pesc_regs_chk.sv
// Purpose: port-level checks of the extended status and control bank
// Assumes: one clock, rstn active low
// Notes:   bound into every pesc_regs instance
`timescale 1ns/10ps
module pesc_regs_chk (
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // register access
  input wire [4:0]  regAddr,
  input wire [15:0] regWrData,
  input wire        regWrEn,
  input wire        regRdEn,
  input wire [15:0] regRdData,
  input wire [4:0]  extWrAddr,
  input wire [15:0] extWrData,
  input wire        extWrEn,
  input wire        swReset,
  // core side
  input wire [6:0]  gigEvents,
  input wire        forcedSpeedLow,
  input wire        txDisable,
  input wire        autoMdixOff,
  input wire        macAnegEn,
  input wire        macProto1000x,
  input wire        preferCopper,
  input wire [2:0]  mediaMode,
  input wire        autoMediaSel,
  input wire        farEndLoop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [3:0] upCnt; // cycles since reset, saturating
  // counts out strap loading after reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) upCnt <= 4'h0;
    else if (upCnt != 4'hf) upCnt <= upCnt + 4'h1;
  end
  // steps of a read-clear access
  sequence s_lock;
    gigEvents[6] ##1 regRdEn && regAddr == 5'h11 ##1 !regRdEn;
  endsequence
  sequence s_rdq;
    regRdEn && regAddr == 5'h11 && gigEvents == 7'h0;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_tx_write: assert property (
    regWrEn && regAddr == 5'h12 |=> txDisable == $past(regWrData[15]))
    else $error("transmit disable not taken from write");
  a_ext_bcast: assert property (
    extWrEn && extWrAddr == 5'h12 && !regWrEn && !swReset
    |=> txDisable == $past(extWrData[15]))
    else $error("broadcast write not applied");
  a_sr_default: assert property (
    swReset && !regWrEn && !extWrEn |=> !txDisable && !farEndLoop)
    else $error("non-sticky bits kept over soft reset");
  a_mdix_free: assert property (
    !forcedSpeedLow |=> !autoMdixOff)
    else $error("crossover off without forced speed");
  a_auto_media: assert property (
    1'b1 |=> autoMediaSel == ($past(mediaMode) >= 3'h5))
    else $error("auto media select does not follow mode");
  a_mode_hold: assert property (
    upCnt == 4'hf && !swReset |=>
    $stable({macAnegEn, macProto1000x, preferCopper, mediaMode}))
    else $error("mode bits changed without soft reset");
  a_lock_err: assert property (
    s_lock |=> regRdData[14])
    else $error("lock error not latched");
  a_rd_clear: assert property (
    s_rdq ##1 s_rdq ##1 !regRdEn |=> (regRdData & 16'h6f80) == 16'h0)
    else $error("event flag not cleared by read");
  a_unmapped_zero: assert property (
    regRdEn && regAddr == 5'h13 ##1 !regRdEn |=> regRdData == 16'h0)
    else $error("unmapped address reads nonzero");
endmodule // pesc_regs_chk

bind pesc_regs pesc_regs_chk pesc_regs_chk_i (
  .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .extWrAddr(extWrAddr), .extWrData(extWrData), .extWrEn(extWrEn),
  .swReset(swReset), .gigEvents(gigEvents),
  .forcedSpeedLow(forcedSpeedLow), .txDisable(txDisable),
  .autoMdixOff(autoMdixOff), .macAnegEn(macAnegEn),
  .macProto1000x(macProto1000x), .preferCopper(preferCopper),
  .mediaMode(mediaMode), .autoMediaSel(autoMediaSel),
  .farEndLoop(farEndLoop));

//--- verif/test_pesc_regs.sv
// Purpose: directed register tests of the extended bank
// Assumes: inputs change 1 ns after rising clk
// Notes:   straps fixed: clock out on, MAC autoneg on, media mode 6
`timescale 1ns/10ps
module test_pesc_regs;
  logic        clk, rstn, strapClkOut, strapMacAneg, eepromSense;
  logic [2:0]  strapMedia;
  logic        gigDescrLock, gigLinkUp, tenLinkUp, forcedSpeedLow;
  logic [6:0]  gigEvents;
  logic        tenEofErr, tenDisconnect, sgmiiAlignErr;
  logic [15:0] v;
  int          failures, nChecks;
  wire  [4:0]  regAddr, extWrAddr;
  wire  [15:0] regWrData, extWrData, regRdData, ctl, mm;
  wire         regWrEn, regRdEn, extWrEn, swReset, txDisable, testClkEn;
  wire         autoMdixOff, pairSwapOff, polarityCorrOff, parallelDetHonour;
  wire         nextPageAutoOff, clkOutEn, forceLinkPass, jabberOff, echoOff;
  wire  [1:0]  squelchSel, mediaOverride;
  wire  [2:0]  mediaMode;
  wire         bcastWrEn, macAnegEn, macProto1000x, preferCopper;
  wire         autoMediaSel, farEndLoop;
  // packed control views
  assign ctl = {txDisable, testClkEn, autoMdixOff, pairSwapOff,
    polarityCorrOff, parallelDetHonour, nextPageAutoOff, clkOutEn,
    forceLinkPass, jabberOff, echoOff, squelchSel, bcastWrEn, 2'h0};
  assign mm = {6'h0, macAnegEn, macProto1000x, preferCopper, mediaMode,
    autoMediaSel, mediaOverride, farEndLoop};
  pesc_regs pesc_regs_i (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .extWrAddr(extWrAddr), .extWrData(extWrData),
    .extWrEn(extWrEn), .swReset(swReset), .strapClkOut(strapClkOut),
    .strapMacAneg(strapMacAneg), .strapMedia(strapMedia),
    .eepromSense(eepromSense), .gigDescrLock(gigDescrLock),
    .gigLinkUp(gigLinkUp), .tenLinkUp(tenLinkUp), .gigEvents(gigEvents),
    .tenEofErr(tenEofErr), .tenDisconnect(tenDisconnect),
    .sgmiiAlignErr(sgmiiAlignErr), .forcedSpeedLow(forcedSpeedLow),
    .txDisable(txDisable), .testClkEn(testClkEn), .autoMdixOff(autoMdixOff),
    .pairSwapOff(pairSwapOff), .polarityCorrOff(polarityCorrOff),
    .parallelDetHonour(parallelDetHonour), .clkOutEn(clkOutEn),
    .nextPageAutoOff(nextPageAutoOff), .forceLinkPass(forceLinkPass),
    .jabberOff(jabberOff), .echoOff(echoOff), .squelchSel(squelchSel),
    .bcastWrEn(bcastWrEn), .macAnegEn(macAnegEn), .mediaMode(mediaMode),
    .macProto1000x(macProto1000x), .preferCopper(preferCopper),
    .autoMediaSel(autoMediaSel), .mediaOverride(mediaOverride),
    .farEndLoop(farEndLoop));
  pesc_smi_host pesc_smi_host_i (.clk(clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .extWrAddr(extWrAddr), .extWrData(extWrData),
    .extWrEn(extWrEn), .swReset(swReset));
  always #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // compare a register read
  task chkr(input logic [15:0] got, exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  // compare a packed control view
  task chko(input logic [15:0] got, exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t ctl got %h exp %h", $time, got, exp);
    end
  endtask
  // read with n strobe cycles and compare
  task rc(input logic [4:0] a, input int n, input logic [15:0] exp);
    pesc_smi_host_i.rd(a, n, v);
    chkr(v, exp);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rstn, forcedSpeedLow} = 3'h0;
    {strapClkOut, strapMacAneg, eepromSense, strapMedia} = 6'h3e;
    {gigDescrLock, gigLinkUp, tenLinkUp} = 3'h0;
    {gigEvents, tenEofErr, tenDisconnect, sgmiiAlignErr} = 10'h0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk) #1;
    rc(5'h11, 1, 16'h0000);
    rc(5'h12, 1, 16'h0089);
    rc(5'h16, 1, 16'h2200);
    rc(5'h17, 1, 16'h2601);
    chko(ctl, 16'h0520);
    chko(mm, 16'h0268);
    done("defaults");
    {gigDescrLock, gigLinkUp, tenLinkUp} = 3'h7;
    {gigEvents, tenEofErr, tenDisconnect, sgmiiAlignErr} = 10'h3ff;
    @(posedge clk) #1;
    {gigEvents, tenEofErr, tenDisconnect, sgmiiAlignErr} = 10'h0;
    rc(5'h11, 1, 16'hff80);
    rc(5'h16, 1, 16'h23c0);
    rc(5'h17, 1, 16'h2603);
    rc(5'h11, 2, 16'h9000);
    rc(5'h16, 1, 16'h2240);
    rc(5'h17, 1, 16'h2601);
    fork
      pesc_smi_host_i.rd(5'h11, 1, v);
      begin
        gigEvents = 7'h01;
        @(posedge clk) #1;
        gigEvents = 7'h00;
      end
    join
    rc(5'h11, 1, 16'h9080);
    rc(5'h11, 1, 16'h9000);
    done("events");
    pesc_smi_host_i.wr(5'h12, 16'hffff);
    chko(ctl, 16'hdf20);
    forcedSpeedLow = 1'b1;
    repeat (2) @(posedge clk) #1;
    chko(ctl, 16'hff20);
    forcedSpeedLow = 1'b0;
    rc(5'h12, 1, 16'h81bb);
    pesc_smi_host_i.wr(5'h16, 16'hffff);
    chko(ctl, 16'hdffc);
    for (int k = 0; k < 3; k++) begin
      pesc_smi_host_i.wr(5'h16, 16'he201 | (k[15:0] << 10));
      chko({14'h0, squelchSel}, k[15:0]);
    end
    rc(5'h16, 1, 16'hea41);
    done("controls");
    pesc_smi_host_i.sr();
    rc(5'h12, 1, 16'h00bb);
    rc(5'h16, 1, 16'hea41);
    chko(ctl, 16'h1ff4);
    pesc_smi_host_i.ext_wr(5'h12, 16'h8000);
    chko(ctl, 16'h80f4);
    pesc_smi_host_i.wr(5'h16, 16'h0000);
    pesc_smi_host_i.sr();
    rc(5'h12, 1, 16'h0089);
    rc(5'h16, 1, 16'h2040);
    chko(ctl, 16'h0520);
    done("soft reset");
    pesc_smi_host_i.wr(5'h17, 16'h1d88);
    chko(mm, 16'h026d);
    rc(5'h17, 1, 16'h1d89);
    pesc_smi_host_i.sr();
    chko(mm, 16'h01d8);
    rc(5'h17, 1, 16'h1d01);
    for (int m = 0; m < 8; m++) begin
      pesc_smi_host_i.wr(5'h17, (m[15:0] << 8) | ((m[15:0] % 3) << 6));
      chko({14'h0, mediaOverride}, m[15:0] % 3);
      pesc_smi_host_i.sr();
      chko(mm, (m[15:0] << 4) | (m >= 5 ? 16'h8 : 16'h0));
    end
    pesc_smi_host_i.wr(5'h13, 16'hffff);
    rc(5'h13, 1, 16'h0000);
    done("media");
    stop_test();
  end
endmodule // test_pesc_regs
